// ---- rtl/gpsel_top.sv ----
// top of the pin output selector: wishbone slave, control, pin drive, interrupts
//
// Register access over Wishbone was chosen for this implementation.
`timescale 1ns/1ps
module gpsel_top (
    input  wire logic                        clk_i,
    input  wire logic                        rst_i,
    input  wire logic                        wb_cyc_i,
    input  wire logic                        wb_stb_i,
    input  wire logic                        wb_we_i,
    input  wire logic [7:0]                  wb_adr_i,
    input  wire logic [3:0]                  wb_sel_i,
    input  wire logic [31:0]                 wb_dat_i,
    output logic [31:0]                      wb_dat_o,
    output logic                             wb_ack_o,
    input  wire gpsel_pkg::gpsel_rx_t [3:0]  rx_i,
    input  wire gpsel_pkg::gpsel_tx_t        tx_i,
    input  wire logic                        frame_sync_pulse_i,
    output logic                             pin_o,
    output logic                             pin_oe_o,
    output logic                             irq_o
);
    import gpsel_pkg::*;

    gpsel_ctrl_t      ctrl;
    logic [3:0]       rx_enable;
    logic [3:0]       tx_port_select;
    logic [IRQ_W-1:0] irq_status;
    logic [IRQ_W-1:0] irq_mask;
    logic [IRQ_W-1:0] events;
    logic [IRQ_W-1:0] next_irq_status;
    logic [31:0]      next_rdata;
    logic             wb_req;
    logic             wr_lane0;
    logic             rd_status;
    logic             sel_sig;
    logic             sel_rsvd;
    logic             next_pin;
    logic             pin_rise;
    logic             pin_fall;
    logic             rsvd_rise;

    // one request per ack; the ack drop forces a gap
    assign wb_req    = wb_cyc_i & wb_stb_i & ~wb_ack_o;
    assign wr_lane0  = wb_req & wb_we_i & wb_sel_i[0];
    assign rd_status = wb_req & ~wb_we_i & gpsel_hit(wb_adr_i, STAT_IDX);

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wb_ack_o <= 1'b0;
        end else begin
            wb_ack_o <= wb_req;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ctrl <= gpsel_ctrl_t'(CTRL_RST);
        end else if (wr_lane0 && gpsel_hit(wb_adr_i, CTRL_IDX)) begin
            ctrl <= gpsel_ctrl_t'(wb_dat_i[7:0]);
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            rx_enable      <= RXEN_RST;
            tx_port_select <= TXSEL_RST;
        end else if (wr_lane0) begin
            if (gpsel_hit(wb_adr_i, RXEN_IDX)) begin
                rx_enable <= wb_dat_i[3:0];
            end
            if (gpsel_hit(wb_adr_i, TXSEL_IDX)) begin
                tx_port_select <= wb_dat_i[3:0];
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            irq_mask <= '0;
        end else if (wr_lane0 && gpsel_hit(wb_adr_i, MASK_IDX)) begin
            irq_mask <= wb_dat_i[IRQ_W-1:0];
        end
    end

    // unmapped words read zero and swallow writes
    always_comb begin
        next_rdata = 32'h0000_0000;
        if (gpsel_hit(wb_adr_i, CTRL_IDX)) begin
            next_rdata[7:0] = ctrl;
        end else if (gpsel_hit(wb_adr_i, RXEN_IDX)) begin
            next_rdata[3:0] = rx_enable;
        end else if (gpsel_hit(wb_adr_i, TXSEL_IDX)) begin
            next_rdata[3:0] = tx_port_select;
        end else if (gpsel_hit(wb_adr_i, STAT_IDX)) begin
            next_rdata[IRQ_W-1:0] = irq_status;
        end else if (gpsel_hit(wb_adr_i, MASK_IDX)) begin
            next_rdata[IRQ_W-1:0] = irq_mask;
        end else if (gpsel_hit(wb_adr_i, PIN_IDX)) begin
            next_rdata[1:0] = {pin_oe_o, pin_o};
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wb_dat_o <= 32'h0000_0000;
        end else if (wb_req && !wb_we_i) begin
            wb_dat_o <= next_rdata;
        end
    end

    gpsel_mux u_mux (
        .ctrl_i             (ctrl),
        .rx_i               (rx_i),
        .tx_i               (tx_i),
        .rx_enable_i        (rx_enable),
        .tx_port_select_i   (tx_port_select),
        .frame_sync_pulse_i (frame_sync_pulse_i),
        .sig_o              (sel_sig),
        .reserved_o         (sel_rsvd)
    );

    // a disabled pin holds its data low as well
    assign next_pin = ctrl.en & sel_sig;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            pin_o    <= 1'b0;
            pin_oe_o <= 1'b0;
        end else begin
            pin_o    <= next_pin;
            pin_oe_o <= ctrl.en;
        end
    end

    gpsel_edge u_pin_edge (
        .clk_i  (clk_i),
        .rst_i  (rst_i),
        .d_i    (pin_o),
        .rise_o (pin_rise),
        .fall_o (pin_fall)
    );

    gpsel_edge u_rsvd_edge (
        .clk_i  (clk_i),
        .rst_i  (rst_i),
        .d_i    (sel_rsvd),
        .rise_o (rsvd_rise),
        .fall_o ()
    );

    always_comb begin
        events           = '0;
        events[IRQ_RISE] = pin_rise;
        events[IRQ_FALL] = pin_fall;
        events[IRQ_RSVD] = rsvd_rise;
    end

    // an event in the clearing read's cycle survives it
    assign next_irq_status = (rd_status ? '0 : irq_status) | events;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            irq_status <= '0;
        end else begin
            irq_status <= next_irq_status;
        end
    end

    assign irq_o = |(irq_status & irq_mask);

    // checks
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);

    logic       h_val;
    logic       h_en;
    logic [3:0] h_lock;
    logic [3:0] h_pass;
    logic [1:0] h_port;
    logic       h_port_lock;
    logic       h_port_pin3;

    always_comb begin
        for (int i = 0; i < 4; i++) begin
            h_lock[i] = rx_i[i].lock;
            h_pass[i] = rx_i[i].pass;
        end
    end

    assign h_val       = ctrl.val;
    assign h_en        = ctrl.en;
    assign h_port      = ctrl.src[1:0];
    assign h_port_lock = rx_i[h_port].lock;
    assign h_port_pin3 = rx_i[h_port].remote_pin[3];

    sequence s_ctrl_write;
        wr_lane0 && gpsel_hit(wb_adr_i, CTRL_IDX);
    endsequence

    sequence s_acked;
        wb_ack_o ##1 !wb_ack_o;
    endsequence

    sequence s_dev_sel(logic [2:0] code);
        ctrl.en && ctrl.src == SRC_DEV && ctrl.sel == code;
    endsequence

    sequence s_tx_sel(logic [2:0] code);
        ctrl.en && ctrl.src == SRC_TX && ctrl.sel == code;
    endsequence

    a_oe_tracks_en: assert property (
        ##1 pin_oe_o == $past(h_en)
    ) else $error("pin enable does not follow control bit 0");

    a_pin_quiet_off: assert property (
        !pin_oe_o |-> !pin_o
    ) else $error("pin data high while driver is off");

    a_ctrl_write_ack: assert property (
        s_ctrl_write |=> s_acked ##0 (ctrl == gpsel_ctrl_t'($past(wb_dat_i[7:0], 1)))
    ) else $error("control write not stored or not acknowledged once");

    a_rx_pin3: assert property (
        ctrl.en && !ctrl.src[2] && ctrl.sel == 3'h3 |=> pin_o == $past(h_port_pin3)
    ) else $error("rx port remote pin 3 not forwarded");

    a_rx_lock: assert property (
        ctrl.en && !ctrl.src[2] && ctrl.sel == SEL_RX_LOCK |=> pin_o == $past(h_port_lock)
    ) else $error("rx port lock not forwarded");

    a_dev_value: assert property (
        s_dev_sel(SEL_DEV_VAL) |=> pin_o == $past(h_val)
    ) else $error("local value bit not driven");

    a_dev_lock_or: assert property (
        s_dev_sel(SEL_DEV_OR) |=> pin_o == $past(|(h_lock & rx_enable))
    ) else $error("lock OR over enabled ports wrong");

    a_dev_lock_and: assert property (
        s_dev_sel(SEL_DEV_AND) && rx_enable == 4'hf |=> pin_o == $past(&h_lock)
    ) else $error("lock AND over enabled ports wrong");

    a_dev_reserved: assert property (
        ctrl.src == SRC_DEV && ctrl.sel > SEL_DEV_FS |=> !pin_o
    ) else $error("reserved status code drives the pin");

    a_tx_pass_or: assert property (
        s_tx_sel(SEL_TX_POR) |=> pin_o == $past(|(h_pass & tx_port_select))
    ) else $error("pass OR over selected ports wrong");

    a_tx_line_valid: assert property (
        s_tx_sel(SEL_TX_LV) |=> pin_o == $past(tx_i.line_valid)
    ) else $error("transmit line valid not forwarded");

    a_tx_synced: assert property (
        s_tx_sel(SEL_TX_SYNC) |=> pin_o == $past(tx_i.synced)
    ) else $error("synchronized flag not forwarded");

    a_tx_irq: assert property (
        s_tx_sel(SEL_TX_IRQ) |=> pin_o == $past(tx_i.irq)
    ) else $error("transmit interrupt not forwarded");

    a_src_reserved: assert property (
        ctrl.src == 3'h5 || ctrl.src == 3'h7 |=> !pin_o
    ) else $error("reserved source drives the pin");

    a_rise_sticky: assert property (
        pin_rise |=> irq_status[IRQ_RISE] ##1 (irq_status[IRQ_RISE] || $past(rd_status))
    ) else $error("pin rise flag not held");

    a_irq_level: assert property (
        irq_o == |(irq_status & irq_mask)
    ) else $error("interrupt level disagrees with status and mask");
endmodule : gpsel_top

// ---- rtl/gpsel_pkg.sv ----
// package of the pin output selector: register map, fields, codes, helpers
// Notes on behaviour
// - pin driver is enabled only while control bit 0 is one
// - bits 4:2 pick group: rx port 0..3, device status, transmit port
// - rx group codes 000..011 forward that port's received remote pins 0..3
// - rx group codes 100..111 give lock, pass, frame valid, line valid
// - status group code 000 drives the stored local value bit 1
// - status codes 001 and 010 give OR and AND of enabled lock
// - status group gives frame sync on one code; 101..111 reserved
// - transmit codes 000 and 001 give AND and OR of selected pass
// - transmit group gives frame valid and line valid (code 011)
// - transmit code 100 gives the multi-port synchronized flag
// - transmit code 101 gives transmit interrupt; codes 110 and 111 reserved
package gpsel_pkg;
    localparam logic [7:0] CTRL_IDX   = 8'h13;
    localparam logic [7:0] RXEN_IDX   = 8'h20;
    localparam logic [7:0] TXSEL_IDX  = 8'h21;
    localparam logic [7:0] STAT_IDX   = 8'h22;
    localparam logic [7:0] MASK_IDX   = 8'h23;
    localparam logic [7:0] PIN_IDX    = 8'h24;
    localparam int unsigned EN_BIT    = 0;
    localparam int unsigned VAL_BIT   = 1;
    localparam int unsigned SRC_LSB   = 2;
    localparam int unsigned SEL_LSB   = 5;
    localparam logic [7:0] CTRL_RST   = 8'h00;
    localparam logic [3:0] RXEN_RST   = 4'hf;
    localparam logic [3:0] TXSEL_RST  = 4'hf;
    localparam int unsigned IRQ_W     = 3;
    localparam int unsigned IRQ_RISE  = 0;
    localparam int unsigned IRQ_FALL  = 1;
    localparam int unsigned IRQ_RSVD  = 2;
    localparam logic [2:0] SRC_DEV    = 3'h4;
    localparam logic [2:0] SRC_TX     = 3'h6;
    localparam logic [2:0] SEL_RX_LOCK = 3'h4;
    localparam logic [2:0] SEL_RX_PASS = 3'h5;
    localparam logic [2:0] SEL_RX_FV   = 3'h6;
    localparam logic [2:0] SEL_RX_LV   = 3'h7;
    localparam logic [2:0] SEL_DEV_VAL = 3'h0;
    localparam logic [2:0] SEL_DEV_OR  = 3'h1;
    localparam logic [2:0] SEL_DEV_AND = 3'h2;
    localparam logic [2:0] SEL_DEV_PAND = 3'h3;
    localparam logic [2:0] SEL_DEV_FS  = 3'h4;
    localparam logic [2:0] SEL_TX_PAND = 3'h0;
    localparam logic [2:0] SEL_TX_POR  = 3'h1;
    localparam logic [2:0] SEL_TX_FV   = 3'h2;
    localparam logic [2:0] SEL_TX_LV   = 3'h3;
    localparam logic [2:0] SEL_TX_SYNC = 3'h4;
    localparam logic [2:0] SEL_TX_IRQ  = 3'h5;

    typedef struct packed {
        logic [2:0] sel;
        logic [2:0] src;
        logic       val;
        logic       en;
    } gpsel_ctrl_t;

    typedef struct packed {
        logic [3:0] remote_pin;
        logic       lock;
        logic       pass;
        logic       frame_valid;
        logic       line_valid;
    } gpsel_rx_t;

    typedef struct packed {
        logic frame_valid;
        logic line_valid;
        logic synced;
        logic irq;
    } gpsel_tx_t;

    function automatic logic gpsel_hit(input logic [7:0] adr, input logic [7:0] idx);
        return adr[7:2] == idx[5:0];
    endfunction : gpsel_hit

    // an empty mask gives zero for both reductions
    function automatic logic gpsel_and(input logic [3:0] v, input logic [3:0] m);
        return (m != 4'h0) && (&(v | ~m));
    endfunction : gpsel_and

    function automatic logic gpsel_or(input logic [3:0] v, input logic [3:0] m);
        return |(v & m);
    endfunction : gpsel_or
endpackage : gpsel_pkg

// ---- rtl/gpsel_edge.sv ----
// edge detector giving one-cycle rise and fall pulses
`timescale 1ns/1ps
module gpsel_edge (
    input  wire logic clk_i,
    input  wire logic rst_i,
    input  wire logic d_i,
    output logic      rise_o,
    output logic      fall_o
);
    import gpsel_pkg::*;

    logic prev;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            prev <= 1'b0;
        end else begin
            prev <= d_i;
        end
    end

    assign rise_o = d_i & ~prev;
    assign fall_o = ~d_i & prev;
endmodule : gpsel_edge

// ---- rtl/gpsel_mux.sv ----
// signal selector for the pin: group and signal decode
`timescale 1ns/1ps
module gpsel_mux (
    input  wire gpsel_pkg::gpsel_ctrl_t      ctrl_i,
    input  wire gpsel_pkg::gpsel_rx_t [3:0]  rx_i,
    input  wire gpsel_pkg::gpsel_tx_t        tx_i,
    input  wire logic [3:0]                  rx_enable_i,
    input  wire logic [3:0]                  tx_port_select_i,
    input  wire logic                        frame_sync_pulse_i,
    output logic                             sig_o,
    output logic                             reserved_o
);
    import gpsel_pkg::*;

    logic [3:0] lock_v;
    logic [3:0] pass_v;
    gpsel_rx_t  port;

    always_comb begin
        for (int i = 0; i < 4; i++) begin
            lock_v[i] = rx_i[i].lock;
            pass_v[i] = rx_i[i].pass;
        end
    end

    // reserved codes drive a quiet low level
    always_comb begin
        port       = rx_i[ctrl_i.src[1:0]];
        sig_o      = 1'b0;
        reserved_o = 1'b0;
        if (!ctrl_i.src[2]) begin
            case (ctrl_i.sel)
                SEL_RX_LOCK: sig_o = port.lock;
                SEL_RX_PASS: sig_o = port.pass;
                SEL_RX_FV:   sig_o = port.frame_valid;
                SEL_RX_LV:   sig_o = port.line_valid;
                default:     sig_o = port.remote_pin[ctrl_i.sel[1:0]];
            endcase
        end else if (ctrl_i.src == SRC_DEV) begin
            case (ctrl_i.sel)
                SEL_DEV_VAL:  sig_o = ctrl_i.val;
                SEL_DEV_OR:   sig_o = gpsel_or(lock_v, rx_enable_i);
                SEL_DEV_AND:  sig_o = gpsel_and(lock_v, rx_enable_i);
                SEL_DEV_PAND: sig_o = gpsel_and(pass_v, rx_enable_i);
                SEL_DEV_FS:   sig_o = frame_sync_pulse_i;
                default:      reserved_o = 1'b1;
            endcase
        end else if (ctrl_i.src == SRC_TX) begin
            case (ctrl_i.sel)
                SEL_TX_PAND: sig_o = gpsel_and(pass_v, tx_port_select_i);
                SEL_TX_POR:  sig_o = gpsel_or(pass_v, tx_port_select_i);
                SEL_TX_FV:   sig_o = tx_i.frame_valid;
                SEL_TX_LV:   sig_o = tx_i.line_valid;
                SEL_TX_SYNC: sig_o = tx_i.synced;
                SEL_TX_IRQ:  sig_o = tx_i.irq;
                default:     reserved_o = 1'b1;
            endcase
        end else begin
            reserved_o = 1'b1;
        end
    end
endmodule : gpsel_mux

// ---- tb/gpsel_board.sv ----
// board-side model of the pin: pull-down on the wire, counts pulses seen
`timescale 1ns/1ps
module gpsel_board (
    input  wire logic  clk_i,
    input  wire logic  rst_i,
    input  wire logic  pin_i,
    input  wire logic  pin_oe_i,
    output logic       line_o,
    output logic [7:0] rises_o
);
    logic last;
    // a released pin falls to the pull-down, never keeps the last value
    assign line_o = pin_oe_i ? pin_i : 1'b0;
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            last    <= 1'b0;
            rises_o <= 8'h00;
        end else begin
            last    <= line_o;
            rises_o <= rises_o + {7'h00, line_o & ~last};
        end
    end
endmodule : gpsel_board

// ---- tb/gpsel_bench.sv ----
// self-checking bench for the pin output selector
`timescale 1ns/1ps
module gpsel_bench;
    import gpsel_pkg::*;
    logic            clk_i = 1'b0;
    logic            rst_i = 1'b1;
    logic            cyc   = 1'b0;
    logic            stb   = 1'b0;
    logic            we    = 1'b0;
    logic [7:0]      adr   = 8'h00;
    logic [3:0]      sel   = 4'h0;
    logic [31:0]     wdat  = 32'h0000_0000;
    logic [31:0]     dat_o;
    logic [31:0]     rdat;
    logic            ack, pin, oe, irq, line;
    logic [7:0]      rises;
    gpsel_rx_t [3:0] rx    = '0;
    gpsel_tx_t       tx    = '0;
    logic            fsync = 1'b0;
    int              errors = 0;
    int              total_checks = 0;

    always #2 clk_i = ~clk_i;

    gpsel_top DUT (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
        .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(dat_o),
        .wb_ack_o(ack), .rx_i(rx), .tx_i(tx), .frame_sync_pulse_i(fsync), .pin_o(pin),
        .pin_oe_o(oe), .irq_o(irq));
    gpsel_board u_board (.clk_i(clk_i), .rst_i(rst_i), .pin_i(pin), .pin_oe_i(oe),
        .line_o(line), .rises_o(rises));

    task automatic summarize;
        $display("checks=%0d errors=%0d", total_checks, errors);
        if (errors == 0 && total_checks > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask : summarize

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            errors++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    // classic single cycle; holds everything until ack is sampled high
    task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d,
                       input logic s0);
        int n;
        n = 0;
        @(posedge clk_i);
        cyc  <= 1'b1;
        stb  <= 1'b1;
        we   <= w;
        adr  <= a;
        sel  <= {3'h0, s0};
        wdat <= {24'h00_0000, d};
        do begin
            @(posedge clk_i);
            n++;
        end while (ack !== 1'b1 && n < 50);
        rdat = dat_o;
        if (n >= 50)
            errors++;
        cyc <= 1'b0;
        stb <= 1'b0;
    endtask : bus

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        bus(1'b1, a, d, 1'b1);
    endtask : wr

    task automatic rd(input logic [7:0] a);
        bus(1'b0, a, 8'h00, 1'b1);
    endtask : rd

    // write control, let the pin settle, then judge driver and wire level
    task automatic sel_pin(input logic [7:0] ctl, input logic exp);
        logic e;
        e = exp & ctl[0];
        wr(8'h4c, ctl);
        repeat (2) @(posedge clk_i);
        #1;
        chk({29'h0, oe, pin, line}, {29'h0, ctl[0], e, e});
    endtask : sel_pin

    task automatic t_reset;
        rd(8'h4c);
        chk(rdat, 32'h0000_0000);
        chk({31'h0, oe}, 32'h0000_0000);
    endtask : t_reset

    task automatic t_rx;
        logic [31:0] m;
        for (int p = 0; p < 4; p++) begin
            for (int s = 0; s < 8; s++) begin
                m = 32'h0000_0001 << (p * 8 + ((s < 4) ? 4 + s : 7 - s));
                rx <= m;
                sel_pin({s[2:0], p[2:0], 2'b01}, 1'b1);
                rx <= ~m;
                sel_pin({s[2:0], p[2:0], 2'b01}, 1'b0);
            end
        end
        rx <= 32'hffff_ffff;
        sel_pin(8'h80, 1'b0);
    endtask : t_rx

    task automatic t_dev;
        rx <= '0;
        sel_pin(8'h11, 1'b0);
        sel_pin(8'h13, 1'b1);
        rx <= 32'h0000_0808;
        sel_pin(8'h31, 1'b1);
        sel_pin(8'h51, 1'b0);
        wr(8'h80, 8'h03);
        sel_pin(8'h51, 1'b1);
        wr(8'h80, 8'h00);
        sel_pin(8'h31, 1'b0);
        fsync <= 1'b1;
        sel_pin(8'h91, 1'b1);
        fsync <= 1'b0;
        sel_pin(8'h91, 1'b0);
        // with every rx input and frame sync high, pass AND (code 011) goes high and reserved codes stay low
        rx    <= 32'hffff_ffff;
        fsync <= 1'b1;
        wr(8'h80, 8'h0f);
        sel_pin(8'h71, 1'b1);
        sel_pin(8'hb3, 1'b0);
        sel_pin(8'hd3, 1'b0);
        sel_pin(8'hf3, 1'b0);
        sel_pin(8'h17, 1'b0);
        sel_pin(8'h1f, 1'b0);
        fsync <= 1'b0;
    endtask : t_dev

    task automatic t_tx;
        rx <= 32'h0004_0404;
        sel_pin(8'h19, 1'b0);
        sel_pin(8'h39, 1'b1);
        wr(8'h84, 8'h07);
        sel_pin(8'h19, 1'b1);
        for (int s = 2; s < 6; s++) begin
            tx <= 4'h8 >> (s - 2);
            sel_pin({s[2:0], 5'h19}, 1'b1);
            tx <= ~(4'h8 >> (s - 2));
            sel_pin({s[2:0], 5'h19}, 1'b0);
        end
        tx <= 4'hf;
        sel_pin(8'hd9, 1'b0);
        sel_pin(8'hf9, 1'b0);
    endtask : t_tx

    task automatic t_irq;
        logic [7:0] r0;
        rx <= '0;
        sel_pin(8'h11, 1'b0);
        // the board counts rises over the whole run; judge only this task's share
        r0 = rises;
        rd(8'h88);
        wr(8'h8c, 8'h01);
        sel_pin(8'h13, 1'b1);
        chk({31'h0, irq}, 32'h0000_0001);
        rd(8'h88);
        chk(rdat, 32'h0000_0001);
        @(posedge clk_i);
        #1;
        chk({31'h0, irq}, 32'h0000_0000);
        wr(8'h8c, 8'h00);
        sel_pin(8'h11, 1'b0);
        chk({31'h0, irq}, 32'h0000_0000);
        rd(8'h88);
        chk(rdat, 32'h0000_0002);
        chk({24'h0, rises - r0}, 32'h0000_0001);
    endtask : t_irq

    task automatic t_bus;
        rd(8'hfc);
        chk(rdat, 32'h0000_0000);
        bus(1'b1, 8'h4c, 8'hff, 1'b0);
        rd(8'h4c);
        chk(rdat, 32'h0000_0011);
        wr(8'h90, 8'hff);
        rd(8'h90);
        chk(rdat, 32'h0000_0002);
    endtask : t_bus

    // whole run is a few hundred cycles; this span leaves ample margin
    initial begin
        repeat (20000) @(posedge clk_i);
        errors++;
        summarize();
    end

    initial begin
        repeat (20) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        t_reset();
        t_rx();
        t_dev();
        t_tx();
        t_irq();
        t_bus();
        summarize();
    end
endmodule : gpsel_bench
